// ===== hw/eiv_pkg.sv
package eiv_pkg;

   // Register byte offsets on the APB bus
   localparam logic [7:0] EIV_OFF_CTRL   = 8'h00;
   localparam logic [7:0] EIV_OFF_ENABLE = 8'h04;
   localparam logic [7:0] EIV_OFF_FLAGS  = 8'h08;
   localparam logic [7:0] EIV_OFF_MASK   = 8'h0C;
   localparam logic [7:0] EIV_OFF_PEND   = 8'h10;
   localparam logic [7:0] EIV_OFF_VECTOR = 8'h14;
   localparam logic [7:0] EIV_OFF_PINS   = 8'h18;

   // Field positions
   localparam int EIV_ENA_EXT  = 0;
   localparam int EIV_ENA_PCH  = 1;
   localparam int EIV_ENA_GIE  = 2;
   localparam int EIV_FLG_EXT  = 0;
   localparam int EIV_FLG_PCH  = 1;

   // Widths and counts
   localparam int EIV_NPIN     = 6;
   localparam int EIV_NSRC     = 9;
   localparam int EIV_VEC_W    = 4;

   // Reset values
   localparam logic [1:0]  EIV_RST_SENSE  = 2'h0;
   localparam logic [2:0]  EIV_RST_ENABLE = 3'h0;
   localparam logic [5:0]  EIV_RST_MASK   = 6'h00;
   localparam logic [3:0]  EIV_RESET_VEC  = 4'h0;

   // Sense-control encodings
   typedef enum logic [1:0] {
      EIV_SENSE_LOW  = 2'h0,
      EIV_SENSE_ANY  = 2'h1,
      EIV_SENSE_FALL = 2'h2,
      EIV_SENSE_RISE = 2'h3
   } eiv_sense_t;

   // Source index order; vector address is index plus one
   localparam int EIV_SRC_EXT  = 0;
   localparam int EIV_SRC_PCH  = 1;
   localparam int EIV_SRC_TOV  = 2;
   localparam int EIV_SRC_NVM  = 3;
   localparam int EIV_SRC_CMP  = 4;
   localparam int EIV_SRC_TCA  = 5;
   localparam int EIV_SRC_TCB  = 6;
   localparam int EIV_SRC_WDT  = 7;
   localparam int EIV_SRC_ADC  = 8;

endpackage : eiv_pkg

// ===== hw/eiv_sync_if.sv
`timescale 1ns/1ps
// Synchronised pin levels handed from the pin stage to the controller
interface eiv_sync_if;
   logic       ext_lvl;
   logic [5:0] pc_lvl;
   logic       ext_prev;
   logic [5:0] pc_prev;
   modport src (output ext_lvl, output pc_lvl, output ext_prev,
                output pc_prev);
   modport dst (input ext_lvl, input pc_lvl, input ext_prev,
                input pc_prev);
endinterface : eiv_sync_if

// ===== hw/eiv_pin_sync.sv
`timescale 1ns/1ps
// Three-stage pin synchroniser; level valid once stages two and three agree
module eiv_pin_sync
   import eiv_pkg::*;
#(
   parameter int NPIN = EIV_NPIN
) (
   // Clock and reset
   input  wire logic            pclk,
   input  wire logic            presetn,
   // Raw pins
   input  wire logic            ext_irq_pin,
   input  wire logic [NPIN-1:0] pin_change_inputs,
   // Clean levels
   eiv_sync_if.src              sy
);
   logic [NPIN:0] s1;
   logic [NPIN:0] s2;
   logic [NPIN:0] s3;
   logic [NPIN:0] lvl;
   logic [NPIN:0] prev;

   // Raw pins pass three flops; pins idle high after reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1 <= '1;
         s2 <= '1;
         s3 <= '1;
      end else begin
         s1 <= {pin_change_inputs, ext_irq_pin};
         s2 <= s1;
         s3 <= s2;
      end
   end

   // Accept a new level only where stages two and three agree
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lvl  <= '1;
         prev <= '1;
      end else begin
         lvl  <= (s2 & s3) | (lvl & (s2 ^ s3));
         prev <= lvl;
      end
   end

   assign sy.ext_lvl  = lvl[0];
   assign sy.pc_lvl   = lvl[NPIN:1];
   assign sy.ext_prev = prev[0];
   assign sy.pc_prev  = prev[NPIN:1];
endmodule : eiv_pin_sync

// ===== hw/eiv_top.sv
// Local design decisions: register access over APB and the register offsets.
`timescale 1ns/1ps
// How it works
// - every reset kind lands on vector address zero.
// - nine sources own vectors one to nine, in fixed order.
// - a vector is fetched only for an enabled, pending source.
// - pins trigger regardless of their drive direction.
// - any toggle of a masked-in port pin raises pin change.
// - pin change is flagged even without the I/O clock.
// - dedicated pin triggers on falling, rising or low level.
// - low level keeps requesting while the pin stays low.
// - edge detection runs only while the I/O clock runs.
// - low level detection works with the I/O clock stopped.
// - a vanished low level wakes the core without any vector.
// - sense codes: 0 low, 1 any change, 2 falling, 3 rising.
// - dedicated flag sets on edges, clears by ack or write one.
// - pin change flag sets on change, clears by ack or write one.
// - edge pulses longer than two clocks are caught while the I/O clock runs.
module eiv_top
   import eiv_pkg::*;
#(
   parameter int NPIN = EIV_NPIN
) (
   // Clock and reset
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   // APB slave
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [7:0]           paddr,
   input  wire logic [31:0]          pwdata,
   output logic      [31:0]          prdata,
   output logic                      pready,
   output logic                      pslverr,
   // Pins
   input  wire logic                 ext_irq_pin,
   input  wire logic [NPIN-1:0]      pin_change_inputs,
   // Core side
   input  wire logic                 io_clk_run,
   input  wire logic                 reset_cause,
   input  wire logic [EIV_NSRC-3:0]  periph_req,
   input  wire logic                 vector_ack,
   output logic                      irq_request,
   output logic      [EIV_VEC_W-1:0] irq_vector,
   output logic                      wake
);
   eiv_sync_if sy ();

   logic [1:0]          sense;
   logic [2:0]          enable;
   logic [NPIN-1:0]     pin_change_mask;
   logic                ext_irq_flag;
   logic                pin_change_flag;
   logic [EIV_NSRC-1:0] pend;
   logic [EIV_NSRC-1:0] req_en;
   logic [EIV_NSRC-1:0] irq_mask;
   logic                ext_low;
   logic                ext_edge;
   logic                pc_hit;
   logic                wr_acc;
   logic                rd_acc;
   logic                known;
   logic                clr_ext;
   logic                clr_pch;
   logic [EIV_VEC_W-1:0] next_vector;
   logic                next_request;

   eiv_pin_sync #(.NPIN(NPIN)) u_sync (
      .pclk              (pclk),
      .presetn           (presetn),
      .ext_irq_pin       (ext_irq_pin),
      .pin_change_inputs (pin_change_inputs),
      .sy                (sy)
   );

   // Address decode shared by read and write paths
   function automatic logic eiv_hit(input logic [7:0] a);
      return a == EIV_OFF_CTRL || a == EIV_OFF_ENABLE ||
             a == EIV_OFF_FLAGS || a == EIV_OFF_MASK ||
             a == EIV_OFF_PEND || a == EIV_OFF_VECTOR ||
             a == EIV_OFF_PINS;
   endfunction : eiv_hit

   assign wr_acc = psel && penable && pwrite && pready;
   assign rd_acc = psel && !penable && !pwrite;
   assign known  = eiv_hit(paddr);

   // Low level is taken straight from the clean level, no clock gate
   assign ext_low = !sy.ext_lvl;

   // Edge sense only counts while the I/O clock runs; direction ignored
   always_comb begin
      unique case (eiv_sense_t'(sense))
         EIV_SENSE_ANY:  ext_edge = sy.ext_lvl ^ sy.ext_prev;
         EIV_SENSE_FALL: ext_edge = !sy.ext_lvl && sy.ext_prev;
         EIV_SENSE_RISE: ext_edge = sy.ext_lvl && !sy.ext_prev;
         EIV_SENSE_LOW:  ext_edge = 1'b0;
      endcase
      ext_edge = ext_edge && io_clk_run;
   end

   // Any masked-in toggle; unmasked pins are dropped here
   assign pc_hit = |((sy.pc_lvl ^ sy.pc_prev) & pin_change_mask);

   // Writing one to a FLAGS bit clears that source's flag
   assign clr_ext = wr_acc && paddr == EIV_OFF_FLAGS && pwdata[EIV_FLG_EXT];
   assign clr_pch = wr_acc && paddr == EIV_OFF_FLAGS && pwdata[EIV_FLG_PCH];

   // APB handshake: one wait-free access phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel && !penable;
         pslverr <= psel && !penable && !eiv_hit(paddr);
      end
   end

   // Sense field and enables written by software
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sense           <= EIV_RST_SENSE;
         enable          <= EIV_RST_ENABLE;
         pin_change_mask <= EIV_RST_MASK;
         irq_mask        <= '1;
      end else if (wr_acc && known) begin
         unique case (paddr)
            EIV_OFF_CTRL:   sense  <= pwdata[1:0];
            EIV_OFF_ENABLE: enable <= pwdata[2:0];
            EIV_OFF_MASK:   pin_change_mask <= pwdata[NPIN-1:0];
            EIV_OFF_PEND:   irq_mask <= pwdata[EIV_NSRC-1:0];
            default: ;
         endcase
      end
   end

   // Dedicated flag: set wins over clear; held clear in level mode
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ext_irq_flag <= 1'b0;
      end else if (eiv_sense_t'(sense) == EIV_SENSE_LOW) begin
         ext_irq_flag <= 1'b0;
      end else if (ext_edge) begin
         ext_irq_flag <= 1'b1;
      end else if (clr_ext || (vector_ack &&
                   irq_vector == EIV_VEC_W'(EIV_SRC_EXT + 1))) begin
         ext_irq_flag <= 1'b0;
      end
   end

   // Pin change flag sampled on any clock; set wins over clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_change_flag <= 1'b0;
      end else if (pc_hit) begin
         pin_change_flag <= 1'b1;
      end else if (clr_pch || (vector_ack &&
                   irq_vector == EIV_VEC_W'(EIV_SRC_PCH + 1))) begin
         pin_change_flag <= 1'b0;
      end
   end

   // Pending vector: level mode uses the live pin, never a flag
   always_comb begin
      pend = '0;
      pend[EIV_SRC_EXT] = (eiv_sense_t'(sense) == EIV_SENSE_LOW) ?
                          ext_low : ext_irq_flag;
      pend[EIV_SRC_PCH] = pin_change_flag;
      pend[EIV_NSRC-1:2] = periph_req;
   end

   // Source enables; unenabled vectors never fetched
   always_comb begin
      req_en = irq_mask;
      req_en[EIV_SRC_EXT] = enable[EIV_ENA_EXT];
      req_en[EIV_SRC_PCH] = enable[EIV_ENA_PCH];
   end

   // Priority encoder: lowest index wins
   always_comb begin
      next_vector  = EIV_RESET_VEC;
      next_request = 1'b0;
      for (int i = EIV_NSRC - 1; i >= 0; i--) begin
         if (pend[i] && req_en[i] && enable[EIV_ENA_GIE]) begin
            next_vector  = EIV_VEC_W'(i + 1);
            next_request = 1'b1;
         end
      end
   end

   // Registered request to the core; reset vector after any reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_request <= 1'b0;
         irq_vector  <= EIV_RESET_VEC;
      end else if (reset_cause) begin
         irq_request <= 1'b0;
         irq_vector  <= EIV_RESET_VEC;
      end else begin
         irq_request <= next_request && !vector_ack;
         irq_vector  <= next_vector;
      end
   end

   // Wake on a low level or pin change; without a vector if level gone
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wake <= 1'b0;
      end else begin
         wake <= (ext_low && enable[EIV_ENA_EXT] &&
                  eiv_sense_t'(sense) == EIV_SENSE_LOW) ||
                 (pc_hit && enable[EIV_ENA_PCH]);
      end
   end

   // Read data, captured in the setup cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (rd_acc) begin
         prdata <= 32'h0000_0000;
         unique case (paddr)
            EIV_OFF_CTRL:   prdata[1:0] <= sense;
            EIV_OFF_ENABLE: prdata[2:0] <= enable;
            EIV_OFF_FLAGS:  prdata[1:0] <= {pin_change_flag, ext_irq_flag};
            EIV_OFF_MASK:   prdata[NPIN-1:0] <= pin_change_mask;
            EIV_OFF_PEND:   prdata[EIV_NSRC-1:0] <= irq_mask;
            EIV_OFF_VECTOR: prdata[EIV_VEC_W:0] <= {irq_request, irq_vector};
            EIV_OFF_PINS:   prdata[NPIN:0] <= {sy.pc_lvl, sy.ext_lvl};
            default: ;
         endcase
      end
   end
endmodule : eiv_top

// ===== tb/eiv_core_model.sv
`timescale 1ns/1ps
// Core stand-in: fetches a vector once a request has stood for delay cycles
module eiv_core_model
   import eiv_pkg::*;
(
   // Clock and reset
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   // Controller side
   input  wire logic                 irq_request,
   input  wire logic [EIV_VEC_W-1:0] irq_vector,
   output logic                      vector_ack,
   // Bench control
   input  wire logic                 take_en,
   input  wire logic [3:0]           delay,
   output logic      [EIV_VEC_W-1:0] last_vec
);
   logic [3:0] wait_cnt;

   // Ack is one cycle; counter restarts so a stale request is not taken twice
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         vector_ack <= 1'b0;
         wait_cnt   <= 4'h0;
         last_vec   <= 4'h0;
      end else begin
         vector_ack <= 1'b0;
         if (irq_request && take_en && !vector_ack) begin
            if (wait_cnt >= delay) begin
               vector_ack <= 1'b1;
               last_vec   <= irq_vector;
               wait_cnt   <= 4'h0;
            end else begin
               wait_cnt <= wait_cnt + 4'h1;
            end
         end else begin
            wait_cnt <= 4'h0;
         end
      end
   end
endmodule : eiv_core_model

// ===== tb/eiv_top_props.sv
`timescale 1ns/1ps
module eiv_top_props
   import eiv_pkg::*;
#(
   parameter int NPIN = EIV_NPIN
) (
   // Clock and reset
   input wire logic                 pclk,
   input wire logic                 presetn,
   // APB slave
   input wire logic                 psel,
   input wire logic                 penable,
   input wire logic                 pwrite,
   input wire logic [7:0]           paddr,
   input wire logic [31:0]          prdata,
   input wire logic                 pready,
   input wire logic                 pslverr,
   // Core side
   input wire logic                 reset_cause,
   input wire logic                 irq_request,
   input wire logic [EIV_VEC_W-1:0] irq_vector,
   input wire logic                 wake
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // Bus phase decode
   logic setup;
   logic rd_setup;
   logic mapped;
   assign setup    = psel && !penable;
   assign rd_setup = setup && !pwrite;
   assign mapped   = paddr <= EIV_OFF_PINS && paddr[1:0] == 2'h0;

   a_ready_after_setup: assert property (setup |=> pready && penable)
      else $error("no ready after setup");
   a_ready_in_access: assert property (pready |-> psel && penable)
      else $error("ready outside access");
   a_ready_single: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   a_err_unmapped: assert property (setup && !mapped |=> pslverr)
      else $error("unmapped access not refused");
   a_ok_mapped: assert property (setup && mapped |=> !pslverr)
      else $error("mapped access refused");
   a_rdata_holds: assert property (!$past(rd_setup) |-> $stable(prdata))
      else $error("read data moved without read");
   a_vec_in_range: assert property (irq_vector <= 4'h9)
      else $error("vector beyond last source");
   a_reset_vec_zero: assert property (
      reset_cause ##1 reset_cause |-> irq_vector == EIV_RESET_VEC)
      else $error("reset not on vector zero");

   c_refused: cover property (pslverr);
   c_pin_vec: cover property (irq_request && irq_vector == 4'h2);
   c_wake_req: cover property (wake && irq_request);
endmodule : eiv_top_props

bind eiv_top eiv_top_props #(.NPIN(NPIN)) u_eiv_top_props (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .reset_cause(reset_cause),
   .irq_request(irq_request), .irq_vector(irq_vector), .wake(wake));

// ===== tb/external_interrupt_vectoring_bench.sv
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin bad_count++; \
   $display("[ERR] t=%0t got=%h exp=%h", $time, g, e); end end
module external_interrupt_vectoring_bench
   import eiv_pkg::*;
;
   logic        pclk = 1'b0, presetn = 1'b0;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic        pready, pslverr, er, irq_request, wake, vector_ack;
   logic        ext_irq_pin = 1'b1, io_clk_run = 1'b1, reset_cause = 1'b0;
   logic        take_en = 1'b0;
   logic [5:0]  pin_change_inputs = 6'h3F;
   logic [6:0]  periph_req = 7'h00;
   logic [3:0]  irq_vector, last_vec;
   int          bad_count = 0;
   int          checks_done = 0;

   // 100 MHz bus clock
   always #5 pclk = ~pclk;

   eiv_top u_eiv_top (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .ext_irq_pin(ext_irq_pin), .pin_change_inputs(pin_change_inputs),
      .io_clk_run(io_clk_run), .reset_cause(reset_cause),
      .periph_req(periph_req), .vector_ack(vector_ack),
      .irq_request(irq_request), .irq_vector(irq_vector), .wake(wake));
   eiv_core_model u_eiv_core_model (.pclk(pclk), .presetn(presetn),
      .irq_request(irq_request), .irq_vector(irq_vector),
      .vector_ack(vector_ack), .take_en(take_en), .delay(4'h6),
      .last_vec(last_vec));

   task automatic final_report;
      $display("Checks %0d, mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : final_report

   task automatic idle(input int n);
      repeat (n) @(posedge pclk);
   endtask : idle

   // One transfer; an idle cycle after it keeps psel from toggling twice
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (n >= 16) begin
         bad_count++;
         final_report;
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : bus

   task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      `CHK(rd, e)
   endtask : chk_rd

   // Bounded wait for a given vector to be requested
   task automatic wait_vec(input logic [3:0] v);
      int n;
      n = 0;
      while (!(irq_request === 1'b1 && irq_vector === v) && n < 40) begin
         @(posedge pclk);
         n++;
      end
      if (n >= 40) begin
         bad_count++;
         final_report;
      end
      `CHK(irq_vector, v)
   endtask : wait_vec

   task automatic t_regs;
      chk_rd(EIV_OFF_CTRL, 32'h0);
      chk_rd(EIV_OFF_FLAGS, 32'h0);
      chk_rd(EIV_OFF_MASK, 32'h0);
      chk_rd(EIV_OFF_PEND, 32'h1FF);
      bus(1'b1, 8'h1C, 32'hF);
      `CHK(er, 1'b1)
      chk_rd(8'h1C, 32'h0);
      `CHK(er, 1'b1)
   endtask : t_regs

   // Pin change with the I/O clock stopped; only masked-in pins count
   task automatic t_pin;
      bus(1'b1, EIV_OFF_MASK, 32'h4);
      bus(1'b1, EIV_OFF_ENABLE, 32'h6);
      io_clk_run <= 1'b0;
      pin_change_inputs <= 6'h3E;
      idle(12);
      chk_rd(EIV_OFF_FLAGS, 32'h0);
      pin_change_inputs <= 6'h3A;
      wait_vec(4'h2);
      chk_rd(EIV_OFF_FLAGS, 32'h2);
      bus(1'b1, EIV_OFF_FLAGS, 32'h2);
      idle(2);
      `CHK(irq_request, 1'b0)
      io_clk_run <= 1'b1;
   endtask : t_pin

   task automatic t_sense;
      bus(1'b1, EIV_OFF_ENABLE, 32'h5);
      for (int s = 1; s < 4; s++) begin
         bus(1'b1, EIV_OFF_CTRL, 32'(s));
         bus(1'b1, EIV_OFF_FLAGS, 32'h3);
         ext_irq_pin <= 1'b0;
         idle(8);
         chk_rd(EIV_OFF_FLAGS, {31'h0, s != 3});
         bus(1'b1, EIV_OFF_FLAGS, 32'h3);
         ext_irq_pin <= 1'b1;
         idle(8);
         chk_rd(EIV_OFF_FLAGS, {31'h0, s != 2});
      end
      bus(1'b1, EIV_OFF_CTRL, 32'h2);
      bus(1'b1, EIV_OFF_FLAGS, 32'h3);
      ext_irq_pin <= 1'b0;
      idle(2);
      ext_irq_pin <= 1'b1;
      idle(8);
      chk_rd(EIV_OFF_FLAGS, 32'h1);
      bus(1'b1, EIV_OFF_FLAGS, 32'h3);
      io_clk_run <= 1'b0;
      ext_irq_pin <= 1'b0;
      idle(8);
      chk_rd(EIV_OFF_FLAGS, 32'h0);
      ext_irq_pin <= 1'b1;
      idle(8);
      io_clk_run <= 1'b1;
   endtask : t_sense

   task automatic t_level;
      bus(1'b1, EIV_OFF_CTRL, 32'h0);
      io_clk_run <= 1'b0;
      ext_irq_pin <= 1'b0; // Held low through the checks, then released without being served
      wait_vec(4'h1);
      `CHK(wake, 1'b1)
      idle(20);
      `CHK(irq_request, 1'b1)
      chk_rd(EIV_OFF_FLAGS, 32'h0);
      ext_irq_pin <= 1'b1;
      idle(8);
      `CHK(irq_request, 1'b0)
      io_clk_run <= 1'b1;
   endtask : t_level

   task automatic t_prio;
      bus(1'b1, EIV_OFF_CTRL, 32'h2);
      bus(1'b1, EIV_OFF_FLAGS, 32'h3);
      ext_irq_pin <= 1'b0;
      wait_vec(4'h1);
      periph_req <= 7'h41;
      idle(4);
      `CHK(irq_vector, 4'h1)
      take_en <= 1'b1;
      wait_vec(4'h3);
      take_en <= 1'b0;
      `CHK(last_vec, 4'h1)
      bus(1'b1, EIV_OFF_PEND, 32'h1FB);
      wait_vec(4'h9);
      periph_req <= 7'h00;
      ext_irq_pin <= 1'b1;
      idle(4);
      `CHK(irq_request, 1'b0)
   endtask : t_prio

   task automatic t_rst;
      reset_cause <= 1'b1;
      idle(3);
      `CHK(irq_vector, EIV_RESET_VEC)
      reset_cause <= 1'b0;
   endtask : t_rst

   // Hang guard
   initial begin
      repeat (20000) @(posedge pclk);
      bad_count++;
      final_report;
   end

   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      idle(6);
      t_regs;
      t_pin;
      t_sense;
      t_level;
      t_prio;
      t_rst;
      final_report;
   end
endmodule : external_interrupt_vectoring_bench
